// *** pkg/mrid_consts.vh ***
// Constants for the mid-range instruction decoder
`ifndef MRID_CONSTS_VH
`define MRID_CONSTS_VH

`define MRID_WORD_W 14
`define MRID_QPHASES 4
`define MRID_Q_LAST 2'h3
`define MRID_CLS_BYTE 3'h1
`define MRID_CLS_BIT 3'h2
`define MRID_CLS_LIT 3'h4
`define MRID_ADDR_MSB 6
`define MRID_D_BIT 7
`define MRID_B_LSB 7
`define MRID_OP_MSB 13
`define MRID_OP_LSB 12
`define MRID_OP_BYTE 2'h0
`define MRID_OP_BIT 2'h1
`define MRID_OP_JUMP 2'h2
`define MRID_OP_LIT 2'h3
`define MRID_TMR0_ADDR 7'h01
`define MRID_NOP_WORD 14'h0000
`define MRID_RESET_PC 13'h0000

`endif

// *** rtl/mrid_phase_counter.v ***
// Four-phase sequencer that marks the end of each instruction cycle
`timescale 1ns/1ps
module mrid_phase_counter (
  input wire clk,
  input wire rst_n,
  output reg [1:0] phase,
  output wire cycleEnd
);
`include "mrid_consts.vh"

  assign cycleEnd = (phase == `MRID_Q_LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

endmodule

// *** rtl/mrid_decoder.v ***
// Instruction decoder and one/two-cycle sequencer of the 8-bit core
`timescale 1ns/1ps
`include "mrid_consts.vh"

// Notes on behaviour
// - Each instruction is one 14-bit word of an operation code plus operand fields.
// - Every word falls into exactly one of byte, bit, or literal-and-control classes.
// - For byte operations destination bit 0 writes the accumulator and 1 writes the register.
// - The register address operand picks one location from 0x00 to 0x7F.
// - For bit operations the bit number selects one bit of the addressed 8-bit register.
// - Literal-and-control operations yield an 8-bit or 11-bit immediate.
// - Don't-care encoding bits are ignored so either value decodes identically.
// - Instructions take one cycle unless a test succeeds or the PC changes, then two with a NOP second.
// - One instruction cycle is four oscillator periods and the pipeline advances once per four clocks.
// - Read-modify-write of a port register takes the read value from the pins, not the latch.
// - Writing the timer-zero count register clears the prescaler when it is assigned to that timer.
module mrid_decoder (
  input wire clk,
  input wire rst_n,
  input wire [13:0] progWord,
  output reg [12:0] progAddr,
  input wire [12:0] branchTarget,
  input wire branchTaken,
  input wire skipTaken,
  input wire prescalerToTimer0,
  input wire [6:0] portAddrBase,
  output reg [13:0] instrWord,
  output reg [2:0] instrClass,
  output reg [6:0] regAddr,
  output reg destToReg,
  output reg [2:0] bitNum,
  output reg [7:0] bitMask,
  output reg [7:0] literal8,
  output reg [10:0] literal11,
  output reg lit11Sel,
  output reg [5:0] subOp,
  output reg flushCycle,
  output wire writeEnable,
  output wire accWriteEnable,
  output wire regWriteEnable,
  output wire statusWriteEnable,
  output wire readFromPins,
  output wire clearPrescaler,
  output wire [1:0] qPhase,
  output wire cycleEnd
);

  // ****************************************
  // Sequencer
  // ****************************************
  wire [1:0] phase;
  wire endOfCycle;

  mrid_phase_counter uPhase (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase),
    .cycleEnd(endOfCycle)
  );

  assign qPhase = phase;
  assign cycleEnd = endOfCycle;

  // ****************************************
  // Field extraction of the incoming word
  // ****************************************
  reg [2:0] next_class;
  reg [5:0] next_subOp;
  reg next_lit11;
  wire [1:0] opTop;

  assign opTop = progWord[`MRID_OP_MSB:`MRID_OP_LSB];

  always @* begin
    next_class = `MRID_CLS_LIT;
    next_subOp = 6'h00;
    next_lit11 = 1'b0;
    case (opTop)
      `MRID_OP_BYTE: begin
        next_class = `MRID_CLS_BYTE;
        next_subOp = {2'h0, progWord[11:8]};
      end
      `MRID_OP_BIT: begin
        next_class = `MRID_CLS_BIT;
        next_subOp = {4'h0, progWord[11:10]};
      end
      `MRID_OP_JUMP: begin
        next_class = `MRID_CLS_LIT;
        next_subOp = {5'h00, progWord[11]};
        next_lit11 = 1'b1;
      end
      `MRID_OP_LIT: begin
        next_class = `MRID_CLS_LIT;
        // Low don't-care bits of the literal subcodes are masked off
        case (progWord[11:10])
          2'h0: next_subOp = 6'h10;
          2'h1: next_subOp = 6'h14;
          2'h2: next_subOp = {2'h2, progWord[11:8]};
          default: next_subOp = {2'h3, progWord[11:9], 1'b0};
        endcase
      end
      default: begin
        next_class = `MRID_CLS_LIT;
      end
    endcase
  end

  // ****************************************
  // One/two-cycle sequencer
  // ****************************************
  localparam [1:0] SEQ_RUN = 2'b01;
  localparam [1:0] SEQ_REFILL = 2'b10;

  reg [1:0] seqState;
  reg [1:0] next_seqState;
  wire redirect;
  wire jumpNow;

  // Requests seen in the refill cycle are dropped, so skips cannot chain
  always @* begin
    next_seqState = seqState;
    case (seqState)
      SEQ_RUN: begin
        if (branchTaken | skipTaken) begin
          next_seqState = SEQ_REFILL;
        end
      end
      SEQ_REFILL: begin
        next_seqState = SEQ_RUN;
      end
      default: begin
        next_seqState = SEQ_RUN;
      end
    endcase
  end

  assign redirect = (seqState == SEQ_RUN) && (branchTaken | skipTaken);
  assign jumpNow = (seqState == SEQ_RUN) && branchTaken;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqState <= SEQ_RUN;
    end else if (endOfCycle) begin
      seqState <= next_seqState;
    end
  end

  always @* begin
    flushCycle = (seqState == SEQ_REFILL);
  end

  // ****************************************
  // Pipeline register, advanced once per instruction cycle
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrWord <= `MRID_NOP_WORD;
      instrClass <= `MRID_CLS_BYTE;
      regAddr <= 7'h00;
      destToReg <= 1'b0;
      bitNum <= 3'h0;
      bitMask <= 8'h01;
      literal8 <= 8'h00;
      literal11 <= 11'h000;
      lit11Sel <= 1'b0;
      subOp <= 6'h00;
      progAddr <= `MRID_RESET_PC;
    end else if (endOfCycle) begin
      // A taken branch or skip turns the next fetched word into a NOP
      if (redirect) begin
        instrWord <= `MRID_NOP_WORD;
        instrClass <= `MRID_CLS_BYTE;
        subOp <= 6'h00;
        destToReg <= 1'b0;
      end else begin
        instrWord <= progWord;
        instrClass <= next_class;
        subOp <= next_subOp;
        destToReg <= progWord[`MRID_D_BIT];
      end
      regAddr <= progWord[`MRID_ADDR_MSB:0];
      bitNum <= progWord[`MRID_B_LSB+2:`MRID_B_LSB];
      bitMask <= 8'h01 << progWord[`MRID_B_LSB+2:`MRID_B_LSB];
      literal8 <= progWord[7:0];
      literal11 <= progWord[10:0];
      lit11Sel <= next_lit11;
      if (jumpNow) begin
        progAddr <= branchTarget;
      end else begin
        progAddr <= progAddr + 13'h0001;
      end
    end
  end

  // ****************************************
  // Write steering
  // ****************************************
  wire byteOp;
  wire bitOp;
  wire isNop;
  wire ctrlWord;
  reg stepAcc;
  reg stepReg;
  reg stepStatus;

  assign byteOp = instrClass == `MRID_CLS_BYTE;
  assign bitOp = instrClass == `MRID_CLS_BIT;
  // Word 0000 with don't-care bits 5..6 is the plain no-op
  assign isNop = byteOp && (instrWord[11:7] == 5'h00) && (instrWord[4:0] == 5'h00);
  // Control words share the byte layout with d clear but never load the accumulator
  assign ctrlWord = byteOp && (instrWord[11:7] == 5'h00);

  always @* begin
    stepAcc = 1'b0;
    stepReg = 1'b0;
    stepStatus = 1'b0;
    case (instrClass)
      `MRID_CLS_BYTE: begin
        stepAcc = ~destToReg && ~ctrlWord;
        stepReg = destToReg;
        stepStatus = ~isNop;
      end
      `MRID_CLS_BIT: begin
        stepReg = ~subOp[1];
      end
      `MRID_CLS_LIT: begin
        stepAcc = ~lit11Sel;
        stepStatus = ~lit11Sel;
      end
      default: begin
        stepAcc = 1'b0;
      end
    endcase
  end

  // Writes are held off while the pipeline refills
  assign writeEnable = ~flushCycle;
  assign accWriteEnable = writeEnable && stepAcc;
  assign regWriteEnable = writeEnable && stepReg;
  assign statusWriteEnable = writeEnable && stepStatus;

  // Port reads during read-modify-write come from the pins
  // One extra bit keeps a window near the top of the map from wrapping
  assign readFromPins = (byteOp || bitOp) && (regAddr >= portAddrBase) &&
                        ({1'b0, regAddr} < ({1'b0, portAddrBase} + 8'h05));
  assign clearPrescaler = regWriteEnable && (regAddr == `MRID_TMR0_ADDR) &&
                          prescalerToTimer0 && endOfCycle;

endmodule

// *** test/mrid_prog_mem.sv ***
// Program memory model that feeds fixed instruction words
`timescale 1ns/1ps
module mrid_prog_mem (
  input wire [12:0] progAddr,
  output logic [13:0] progWord
);
  // Empty slots hold a literal op so that a stray fetch shows up
  always_comb begin
    case (progAddr)
      13'h0000: progWord = 14'h0785;
      13'h0001: progWord = 14'h0205;
      13'h0002: progWord = 14'h1fff;
      13'h0004: progWord = 14'h3055;
      13'h0005: progWord = 14'h3355;
      13'h0006: progWord = 14'h0081;
      13'h0007: progWord = 14'h2abc;
      13'h000a: progWord = 14'h0123;
      default: progWord = 14'h3fff;
    endcase
  end
endmodule

// *** test/mrid_decoder_sva.sv ***
// Assertions on the decoder ports
`timescale 1ns/1ps
module mrid_decoder_sva (
  input wire clk,
  input wire rst_n,
  input wire [13:0] progWord,
  input wire [12:0] progAddr,
  input wire [12:0] branchTarget,
  input wire branchTaken,
  input wire skipTaken,
  input wire prescalerToTimer0,
  input wire [13:0] instrWord,
  input wire [2:0] instrClass,
  input wire [6:0] regAddr,
  input wire destToReg,
  input wire [2:0] bitNum,
  input wire [7:0] bitMask,
  input wire [7:0] literal8,
  input wire [10:0] literal11,
  input wire flushCycle,
  input wire accWriteEnable,
  input wire regWriteEnable,
  input wire statusWriteEnable,
  input wire clearPrescaler,
  input wire [1:0] qPhase,
  input wire cycleEnd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    cycleEnd && !flushCycle && !branchTaken && !skipTaken;
  endsequence
  sequence s_jump;
    cycleEnd && !flushCycle && branchTaken;
  endsequence
  a_four_clocks: assert property (cycleEnd |-> qPhase == 2'h3 ##1 !cycleEnd [*3] ##1 cycleEnd)
    else $error("cycle length");
  a_word_taken: assert property (s_take |=> instrWord == $past(progWord))
    else $error("word");
  a_class_map: assert property (s_take |=> instrClass == ($past(progWord[13]) ? 3'h4 : $past(progWord[12]) ? 3'h2 : 3'h1))
    else $error("class");
  a_addr_dest: assert property (s_take |=> regAddr == $past(progWord[6:0]) && destToReg == $past(progWord[7]))
    else $error("addr dest");
  a_bit_select: assert property (s_take |=> bitNum == $past(progWord[9:7]) && bitMask == 8'h01 << bitNum)
    else $error("bit");
  a_literal_fields: assert property (s_take |=> literal8 == $past(progWord[7:0]) && literal11 == $past(progWord[10:0]))
    else $error("literal");
  a_pc_step: assert property (s_take |=> progAddr == $past(progAddr) + 13'h0001)
    else $error("pc step");
  a_branch_flush: assert property (s_jump |=> flushCycle && instrWord == 14'h0000 && progAddr == $past(branchTarget))
    else $error("branch");
  a_refill_ends: assert property (cycleEnd && flushCycle |=> !flushCycle && progAddr == $past(progAddr) + 13'h0001)
    else $error("refill");
  a_flush_quiet: assert property (flushCycle |-> !(accWriteEnable || regWriteEnable || statusWriteEnable))
    else $error("flush write");
  a_prescale_clear: assert property (clearPrescaler |-> qPhase == 2'h3 && prescalerToTimer0 && regAddr == 7'h01)
    else $error("prescaler");
endmodule
bind mrid_decoder mrid_decoder_sva chk (.clk, .rst_n, .progWord, .progAddr, .branchTarget, .branchTaken, .skipTaken,
  .prescalerToTimer0, .instrWord, .instrClass, .regAddr, .destToReg, .bitNum, .bitMask, .literal8, .literal11,
  .flushCycle, .accWriteEnable, .regWriteEnable, .statusWriteEnable, .clearPrescaler, .qPhase, .cycleEnd);

// *** test/tb_top.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, branchTaken = 0, skipTaken = 0, prescalerToTimer0 = 1;
  logic [12:0] branchTarget = 13'h000a;
  logic [6:0] portBase = 7'h05;
  logic [5:0] keptOp;
  wire [13:0] progWord, instrWord;
  wire [12:0] progAddr;
  wire [2:0] instrClass, bitNum;
  wire [6:0] regAddr;
  wire [7:0] bitMask, literal8;
  wire [10:0] literal11;
  wire [5:0] subOp;
  wire [1:0] qPhase;
  wire destToReg, lit11Sel, flushCycle, wrEn, accWe, regWe, stWe, readFromPins, clearPrescaler, cycleEnd;
  int fail_count = 0, checks = 0;
  mrid_prog_mem mem (.progAddr, .progWord);
  mrid_decoder DUT (.clk, .rst_n, .progWord, .progAddr, .branchTarget, .branchTaken, .skipTaken, .prescalerToTimer0,
    .portAddrBase(portBase), .instrWord, .instrClass, .regAddr, .destToReg, .bitNum, .bitMask, .literal8, .literal11,
    .lit11Sel, .subOp, .flushCycle, .writeEnable(wrEn), .accWriteEnable(accWe), .regWriteEnable(regWe),
    .statusWriteEnable(stWe), .readFromPins, .clearPrescaler, .qPhase, .cycleEnd);
  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Offers branch and skip at the fetch edge, returns once fields settle
  task automatic step(input logic br, input logic sk);
    for (int n = 0; n < 8 && cycleEnd !== 1'b1; n++) @(negedge clk);
    branchTaken = br;
    skipTaken = sk;
    @(negedge clk);
    branchTaken = 0;
    skipTaken = 0;
  endtask
  task automatic t_byte;
    step(0, 0);
    chk("class", 3'h1, instrClass);
    chk("addr", 7'h05, regAddr);
    chk("dest", 1'b1, destToReg);
    chk("pins", 1'b1, readFromPins);
    chk("regwe", 1'b1, regWe);
    chk("stwe", 1'b1, stWe);
    step(0, 0);
    chk("dest", 1'b0, destToReg);
    chk("acc", 1'b1, accWe);
    chk("regwe", 1'b0, regWe);
    chk("pc", 13'h0002, progAddr);
    $display("byte done");
  endtask
  task automatic t_bit_skip;
    step(0, 0);
    chk("class", 3'h2, instrClass);
    chk("mask", 8'h80, bitMask);
    chk("regwe", 1'b0, regWe);
    chk("wren", 1'b1, wrEn);
    step(0, 1);
    chk("flush", 1'b1, flushCycle);
    chk("acc", 1'b0, accWe);
    chk("wren", 1'b0, wrEn);
    chk("regwe", 1'b0, regWe);
    chk("stwe", 1'b0, stWe);
    $display("skip done");
  endtask
  task automatic t_literal;
    step(0, 0);
    chk("word", 14'h3055, instrWord);
    chk("class", 3'h4, instrClass);
    chk("acc", 1'b1, accWe);
    keptOp = subOp;
    step(0, 0);
    chk("subop", keptOp, subOp);
    chk("lit8", 8'h55, literal8);
    $display("literal done");
  endtask
  task automatic t_timer;
    step(0, 0);
    chk("clrpre", 1'b0, clearPrescaler);
    chk("regwe", 1'b1, regWe);
    chk("pins", 1'b0, readFromPins);
    for (int n = 0; n < 8 && cycleEnd !== 1'b1; n++) @(negedge clk);
    chk("phase", 2'h3, qPhase);
    chk("clrpre", 1'b1, clearPrescaler);
    prescalerToTimer0 = 0;
    portBase = 7'h00;
    #1;
    chk("clrpre", 1'b0, clearPrescaler);
    chk("pins", 1'b1, readFromPins);
    prescalerToTimer0 = 1;
    portBase = 7'h05;
    $display("timer done");
  endtask
  task automatic t_jump;
    step(0, 0);
    chk("lit11", 11'h2bc, literal11);
    chk("sel11", 1'b1, lit11Sel);
    step(1, 0);
    chk("pc", 13'h000a, progAddr);
    step(1, 1);
    chk("word", 14'h0123, instrWord);
    chk("flush", 1'b0, flushCycle);
    chk("pc", 13'h000b, progAddr);
    $display("jump done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_byte;
    t_bit_skip;
    t_literal;
    t_timer;
    t_jump;
    give_verdict;
  end
  initial begin
    #5000;
    fail_count++;
    give_verdict;
  end
endmodule
